// ==== pm_smi_trap_config_tb_top.sv ====
// testbench: register map, monitor traps, legacy ports, gpi routing, release delay
`timescale 1ns/1ps
module pm_smi_trap_config_tb_top;
  import pmst_pkg::*;
  logic sys_clk = 0, rst_b = 0, cpuSleepRelease = 0, sleeping = 0, rdCfg = 0, rdIo = 0;
  logic commandPortSmiEnable = 0, commandSmiClear = 0, legacyPortDecodeEnable = 0;
  logic [3:0] monitorTrapEnable = 0, monitorTrapClear = 0, monitorTrapStatus;
  logic [15:0] generalInputStatus = 0, generalInputEventEnable = 0, gpioIsInput = 0;
  logic cfgWrite, cfgRead, ioValid, ioWrite, ioPosDecode, ioTargetLpc, ioClaim, lpcForward;
  logic wakeEvent, osControlInterrupt, systemMgmtInterrupt_b, stopClockRelease, cl, fw;
  logic [7:0] cfgAddr, cfgWrData, ioWrData, cfgRdData, ioRdData, b;
  logic [15:0] ioAddr, base;
  logic [7:0] expQ[$];
  logic [23:0] wt[4] = '{24'ha8ff3f, 24'hc0fff0, 24'hbbff3f, 24'h50ff00};
  int err_total = 0, checks = 0, seed = 54346, n, m;
  initial forever #20 sys_clk = ~sys_clk;
  pmst_trap_config #(.GPI_PRESENT(16'h7fff)) dut_u (.sys_clk, .rst_b, .cfgWrite, .cfgRead,
    .cfgAddr, .cfgWrData, .cfgRdData, .ioValid, .ioWrite, .ioAddr, .ioWrData, .ioPosDecode,
    .ioTargetLpc, .ioRdData, .ioClaim, .lpcForward, .monitorTrapStatus, .monitorTrapEnable,
    .monitorTrapClear, .commandPortSmiEnable, .commandSmiClear, .legacyPortDecodeEnable,
    .generalInputStatus, .generalInputEventEnable, .gpioIsInput, .sleeping, .wakeEvent,
    .osControlInterrupt, .systemMgmtInterrupt_b, .cpuSleepRelease, .stopClockRelease);
  pmst_host_model host_u (.sys_clk, .ioClaim, .lpcForward, .cfgWrite, .cfgRead, .ioValid,
    .ioWrite, .ioPosDecode, .ioTargetLpc, .cfgAddr, .cfgWrData, .ioWrData, .ioAddr);
  task automatic check(input string nm, input logic [31:0] exp, seen);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_u.cfg(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    expQ.push_back(e);
    host_u.cfg(1'b0, a, 8'h00);
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d, e,
                    input logic pd);
    if (!w) expQ.push_back(e);
    host_u.io(w, a, d, pd, 1'b1, cl, fw);
  endtask
  // read data is registered, so it is judged one cycle after the strobe
  always @(posedge sys_clk) {rdCfg, rdIo} <= {cfgRead, ioValid & !ioWrite};
  always @(negedge sys_clk) if (rdCfg | rdIo)
    check("rd", expQ.pop_front(), rdCfg ? cfgRdData : ioRdData);
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_b = 1;
    for (n = 0; n < 38; n++)
      rd(8'ha8 + 8'(n), n == 0 ? 8'h0d : 8'h00);
    for (n = 0; n < 4; n++) begin
      wr(wt[n][23:16], wt[n][15:8]);
      rd(wt[n][23:16], wt[n][7:0]);
    end
    $display("test register map done");
    wr(OFF_MON_MASK, 8'h33);
    wr(OFF_MON_MASK + 8'h01, 8'h33);
    wr(OFF_FWD_EN, 8'ha0);
    for (n = 0; n < NUM_MON; n++) begin
      base = {4'(n + 1), 8'($random(seed)), 4'h0};
      wr(OFF_MON4_BASE + 8'(2 * n), base[7:0]);
      wr(OFF_MON4_BASE + 8'(2 * n + 1), base[15:8]);
      rd(OFF_MON4_BASE + 8'(2 * n + 1), base[15:8]);
      monitorTrapEnable = 4'(1 << n);
      io(1'b0, base | 16'h0003, 8'h00, 8'h00, 1'b1);
      check("hit", {1'b0, n[0], 4'(1 << n)}, {systemMgmtInterrupt_b, fw, monitorTrapStatus});
      monitorTrapClear = 4'hf;
      io(1'b0, base | 16'h0004, 8'h00, 8'h00, 1'b1);
      monitorTrapClear = 4'h0;
      check("miss", 6'h20, {systemMgmtInterrupt_b, fw, monitorTrapStatus});
      io(1'b0, base | 16'h0001, 8'h00, 8'h00, 1'b0);
      check("no decode", {n[0], 4'h0}, {fw, monitorTrapStatus});
      monitorTrapEnable = 4'h0;
      io(1'b0, base | 16'h0002, 8'h00, 8'h00, 1'b1);
      check("disabled", {n[0], 4'h0}, {fw, monitorTrapStatus});
    end
    $display("test monitors done");
    b = 8'($random(seed));
    commandPortSmiEnable = 1;
    io(1'b1, IO_CMD_PORT, b, 8'h00, 1'b1);
    check("undecoded", 2'b01, {cl, systemMgmtInterrupt_b});
    legacyPortDecodeEnable = 1;
    io(1'b1, IO_CMD_PORT, b, 8'h00, 1'b1);
    check("cmd smi", 2'b10, {cl, systemMgmtInterrupt_b});
    io(1'b1, IO_SCRATCH_PORT, ~b, 8'h00, 1'b1);
    io(1'b0, IO_CMD_PORT, 8'h00, b, 1'b1);
    io(1'b0, IO_SCRATCH_PORT, 8'h00, ~b, 1'b1);
    commandSmiClear = 1;
    @(negedge sys_clk);
    commandSmiClear = 0;
    check("smi clear", 1'b1, systemMgmtInterrupt_b);
    $display("test legacy ports done");
    {generalInputStatus, generalInputEventEnable, gpioIsInput} = {3{16'h0002}};
    for (n = 0; n < 5; n++) begin
      if (n == 4) gpioIsInput = 16'h0000;
      wr(OFF_GPI_ROUTE, 8'((n == 4 ? 2 : n) << 2));
      check("route", {n == 2, n != 1}, {osControlInterrupt, systemMgmtInterrupt_b});
    end
    wr(OFF_GPI_ROUTE, 8'h00);
    {sleeping, gpioIsInput} = {1'b1, 16'h0002};
    @(negedge sys_clk);
    check("wake", 1'b1, wakeEvent);
    $display("test routing done");
    for (n = 0; n < 2; n++) begin
      b = n == 0 ? 8'h3f : 8'h02;
      wr(OFF_STOP_DELAY, b);
      cpuSleepRelease = 1;
      @(negedge sys_clk);
      cpuSleepRelease = 0;
      for (m = 0; m < 8000 && stopClockRelease !== 1'b1; m++) @(negedge sys_clk);
      if (m == 8000) begin
        err_total++;
        give_verdict();
      end
      check("delay", 1'b1, m == b * DELAY_STEP_CYC || m == b * DELAY_STEP_CYC + 1);
      @(negedge sys_clk);
      check("pulse", 1'b0, stopClockRelease);
    end
    $display("test release delay done");
    rst_b = 0;
    @(negedge sys_clk);
    rst_b = 1;
    io(1'b0, IO_SCRATCH_PORT, 8'h00, 8'h00, 1'b1);
    $display("test second reset done");
    give_verdict();
  end
endmodule

// ==== pmst_host_model.sv ====
// host model: config and i/o cycles as one-cycle strobes on the falling edge
`timescale 1ns/1ps
module pmst_host_model (
  input wire logic sys_clk,
  input wire logic ioClaim,
  input wire logic lpcForward,
  output logic cfgWrite,
  output logic cfgRead,
  output logic ioValid,
  output logic ioWrite,
  output logic ioPosDecode,
  output logic ioTargetLpc,
  output logic [7:0] cfgAddr,
  output logic [7:0] cfgWrData,
  output logic [7:0] ioWrData,
  output logic [15:0] ioAddr
);
  initial begin
    {cfgWrite, cfgRead, ioValid, ioWrite, ioPosDecode, ioTargetLpc} = 6'h00;
    {cfgAddr, cfgWrData, ioWrData, ioAddr} = 40'h00;
  end
  task automatic cfg(input logic w, input logic [7:0] a, d);
    @(negedge sys_clk);
    {cfgWrite, cfgRead, cfgAddr, cfgWrData} = {w, !w, a, d};
    @(negedge sys_clk);
    // idle lines flip so a stale value can never look valid
    {cfgWrite, cfgRead, cfgAddr, cfgWrData} = {2'b00, ~a, ~d};
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
                    input logic pd, lpc, output logic cl, fw);
    @(negedge sys_clk);
    {ioValid, ioWrite, ioAddr, ioWrData, ioPosDecode, ioTargetLpc} = {1'b1, w, a, d, pd, lpc};
    #1 cl = ioClaim;
    fw = lpcForward;
    @(negedge sys_clk);
    {ioValid, ioWrite, ioAddr, ioWrData} = {2'b00, ~a, ~d};
  endtask
endmodule

// ==== pmst_pkg.sv ====
// package: offsets, field layouts, reset values and timing for the pm trap block
package pmst_pkg;
  // configuration space offsets
  localparam logic [7:0] OFF_STOP_DELAY = 8'ha8;
  localparam logic [7:0] OFF_GPI_ROUTE = 8'hb8;
  localparam logic [7:0] OFF_FWD_EN = 8'hc0;
  localparam logic [7:0] OFF_MON4_BASE = 8'hc4;
  localparam logic [7:0] OFF_MON5_BASE = 8'hc6;
  localparam logic [7:0] OFF_MON6_BASE = 8'hc8;
  localparam logic [7:0] OFF_MON7_BASE = 8'hca;
  localparam logic [7:0] OFF_MON_MASK = 8'hcc;
  // fixed i/o ports
  localparam logic [15:0] IO_CMD_PORT = 16'h00b2;
  localparam logic [15:0] IO_SCRATCH_PORT = 16'h00b3;
  // reset values
  localparam logic [5:0] STOP_DELAY_RST = 6'h0d;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
  localparam logic [15:0] HALF_RST = 16'h0000;
  // field layout
  localparam int STOP_DELAY_W = 6;
  localparam int NUM_GPI = 16;
  localparam int NUM_MON = 4;
  localparam int FWD_LSB = 4;
  localparam int MASK_W = 4;
  // route codes
  localparam logic [1:0] ROUTE_NONE = 2'h0;
  localparam logic [1:0] ROUTE_SMI = 2'h1;
  localparam logic [1:0] ROUTE_SCI = 2'h2;
  // delay timing: about 3.88 us per code, so 0dh lands near 50 us and 3fh near 245 us
  localparam int CLK_NS = 40;
  localparam int DELAY_STEP_NS = 3870;
  localparam int DELAY_STEP_CYC = (DELAY_STEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_CNT_W = 7;
endpackage

// ==== pmst_trap_config.sv ====
// pm configuration, gpi routing, i/o monitor traps and legacy pm ports
`timescale 1ns/1ps
module pmst_trap_config
  import pmst_pkg::*;
#(
  parameter logic [15:0] GPI_PRESENT = 16'hffff
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  // configuration space access, byte granular
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  output logic [7:0] cfgRdData,
  // processor i/o cycle, one-cycle strobe per cycle
  input wire logic ioValid,
  input wire logic ioWrite,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic ioPosDecode,
  input wire logic ioTargetLpc,
  output logic [7:0] ioRdData,
  output logic ioClaim,
  output logic lpcForward,
  output logic [3:0] monitorTrapStatus,
  // enables and clear pulses from the pm i/o block
  input wire logic [3:0] monitorTrapEnable,
  input wire logic [3:0] monitorTrapClear,
  input wire logic commandPortSmiEnable,
  input wire logic commandSmiClear,
  input wire logic legacyPortDecodeEnable,
  // general inputs
  input wire logic [15:0] generalInputStatus,
  input wire logic [15:0] generalInputEventEnable,
  input wire logic [15:0] gpioIsInput,
  input wire logic sleeping,
  output logic wakeEvent,
  output logic osControlInterrupt,
  output logic systemMgmtInterrupt_b,
  // stop clock release sequencing
  input wire logic cpuSleepRelease,
  output logic stopClockRelease
);
  import pmst_pkg::*;

  typedef enum logic [1:0] {
    DLY_IDLE = 2'b01,
    DLY_COUNT = 2'b10
  } pmst_dly_e;

  logic [5:0] stopDelay_q;
  logic [31:0] route_q;
  logic [7:4] fwdEn_q;
  logic [15:0] monBase_q [NUM_MON];
  logic [15:0] monMask_q;
  logic [7:0] cmdPort_q;
  logic [7:0] scratch_q;
  logic [3:0] trapSts_q;
  logic cmdSmi_q;
  logic [3:0] monHit;
  logic cmdHit;
  logic scratchHit;
  pmst_dly_e dlyState_q;
  // release delay counters; one step is DELAY_STEP_CYC clocks
  logic [STOP_DELAY_W-1:0] stepsLeft_q;
  logic [STEP_CNT_W-1:0] stepCyc_q;
  logic gpiSmi;

  function automatic logic monMatch(input logic [15:0] addr, input logic [15:0] base,
                                    input logic [3:0] mask);
    monMatch = (addr[15:4] == base[15:4]) &&
               (((addr[3:0] ^ base[3:0]) & ~mask) == 4'h0);
  endfunction

  // configuration registers
  // absent gpi route pairs never load, so they read back zero
  // bases and mask are byte halves, low byte at the even offset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stopDelay_q <= STOP_DELAY_RST;
      route_q <= ROUTE_RST;
      fwdEn_q <= 4'h0;
      monMask_q <= HALF_RST;
      for (int i = 0; i < NUM_MON; i++) begin
        monBase_q[i] <= HALF_RST;
      end
    end else if (cfgWrite) begin
      if (cfgAddr == OFF_STOP_DELAY) begin
        stopDelay_q <= cfgWrData[5:0];
      end
      for (int b = 0; b < 4; b++) begin
        if (cfgAddr == OFF_GPI_ROUTE + 8'(b)) begin
          for (int k = 0; k < 4; k++) begin
            if (GPI_PRESENT[b*4+k]) begin
              route_q[b*8+k*2 +: 2] <= cfgWrData[k*2 +: 2];
            end
          end
        end
      end
      if (cfgAddr == OFF_FWD_EN) begin
        fwdEn_q <= cfgWrData[7:FWD_LSB];
      end
      for (int i = 0; i < NUM_MON; i++) begin
        if (cfgAddr == OFF_MON4_BASE + 8'(2 * i)) begin
          monBase_q[i][7:0] <= cfgWrData;
        end
        if (cfgAddr == OFF_MON4_BASE + 8'(2 * i + 1)) begin
          monBase_q[i][15:8] <= cfgWrData;
        end
      end
      if (cfgAddr == OFF_MON_MASK) begin
        monMask_q[7:0] <= cfgWrData;
      end
      if (cfgAddr == OFF_MON_MASK + 8'h01) begin
        monMask_q[15:8] <= cfgWrData;
      end
    end
  end

  // configuration read mux; reserved bits read zero
  // unmapped offsets fall through to zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgRdData <= BYTE_RST;
    end else if (cfgRead) begin
      cfgRdData <= BYTE_RST;
      if (cfgAddr == OFF_STOP_DELAY) begin
        cfgRdData <= {2'h0, stopDelay_q};
      end
      for (int b = 0; b < 4; b++) begin
        if (cfgAddr == OFF_GPI_ROUTE + 8'(b)) begin
          cfgRdData <= route_q[b*8 +: 8];
        end
      end
      if (cfgAddr == OFF_FWD_EN) begin
        cfgRdData <= {fwdEn_q, 4'h0};
      end
      for (int i = 0; i < NUM_MON; i++) begin
        if (cfgAddr == OFF_MON4_BASE + 8'(2 * i)) begin
          cfgRdData <= monBase_q[i][7:0];
        end
        if (cfgAddr == OFF_MON4_BASE + 8'(2 * i + 1)) begin
          cfgRdData <= monBase_q[i][15:8];
        end
      end
      if (cfgAddr == OFF_MON_MASK) begin
        cfgRdData <= monMask_q[7:0];
      end
      if (cfgAddr == OFF_MON_MASK + 8'h01) begin
        cfgRdData <= monMask_q[15:8];
      end
    end
  end

  // address compare is combinational so the forward decision lands in the cycle
  always_comb begin
    for (int i = 0; i < NUM_MON; i++) begin
      monHit[i] = ioValid && monMatch(ioAddr, monBase_q[i], monMask_q[i*MASK_W +: MASK_W]);
    end
  end

  assign cmdHit = ioValid && legacyPortDecodeEnable && (ioAddr == IO_CMD_PORT);
  assign scratchHit = ioValid && legacyPortDecodeEnable && (ioAddr == IO_SCRATCH_PORT);
  assign ioClaim = cmdHit || scratchHit;
  // forwarding ignores trap enables and positive decode
  assign lpcForward = ioValid && ioTargetLpc && |(monHit & fwdEn_q);

  // trap status: set wins over clear
  // status latches only when some agent decodes the cycle
  // clear pulses come from the pm i/o block
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trapSts_q <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_MON; i++) begin
        if (monHit[i] && monitorTrapEnable[i] && ioPosDecode) begin
          trapSts_q[i] <= 1'b1;
        end else if (monitorTrapClear[i]) begin
          trapSts_q[i] <= 1'b0;
        end
      end
    end
  end
  assign monitorTrapStatus = trapSts_q;

  // legacy ports
  // decode enable gates both ports; addresses are fixed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdPort_q <= BYTE_RST;
      scratch_q <= BYTE_RST;
    end else if (ioWrite) begin
      if (cmdHit) begin
        cmdPort_q <= ioWrData;
      end
      if (scratchHit) begin
        scratch_q <= ioWrData;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmdSmi_q <= 1'b0;
    // command smi stays pending until the handler clears it
    // a write in the clear cycle wins so no command is lost
    end else if (cmdHit && ioWrite && commandPortSmiEnable) begin
      cmdSmi_q <= 1'b1;
    end else if (commandSmiClear) begin
      cmdSmi_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ioRdData <= BYTE_RST;
    // reads outside the two ports return zero
    end else if (ioValid && !ioWrite) begin
      ioRdData <= cmdHit ? cmdPort_q : (scratchHit ? scratch_q : BYTE_RST);
    end
  end

  // gpi routing
  // reserved route code 11 is treated as no effect
  // wake ignores the route field while sleeping
  always_comb begin
    gpiSmi = 1'b0;
    osControlInterrupt = 1'b0;
    wakeEvent = 1'b0;
    for (int n = 0; n < NUM_GPI; n++) begin
      if (GPI_PRESENT[n] && gpioIsInput[n] && generalInputStatus[n] &&
          generalInputEventEnable[n]) begin
        if (route_q[n*2 +: 2] == ROUTE_SMI) begin
          gpiSmi = 1'b1;
        end
        if (route_q[n*2 +: 2] == ROUTE_SCI) begin
          osControlInterrupt = 1'b1;
        end
      end
      if (sleeping && GPI_PRESENT[n] && generalInputStatus[n] &&
          generalInputEventEnable[n]) begin
        wakeEvent = 1'b1;
      end
    end
  end

  // active-low combine; the gpi path is a level, not latched here
  assign systemMgmtInterrupt_b = !(|trapSts_q || cmdSmi_q || gpiSmi);

  // stop clock release delay: code steps of about 3.9 us each
  // a new release request while counting is ignored
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dlyState_q <= DLY_IDLE;
      stepsLeft_q <= '0;
      stepCyc_q <= '0;
      stopClockRelease <= 1'b0;
    end else begin
      stopClockRelease <= 1'b0;
      unique case (dlyState_q)
        DLY_IDLE: begin
          if (cpuSleepRelease) begin
            // codes 00h/01h are illegal; clamp so the delay never collapses
            stepsLeft_q <= (stopDelay_q < 6'h02) ? 6'h02 : stopDelay_q;
            stepCyc_q <= STEP_CNT_W'(DELAY_STEP_CYC - 1);
            dlyState_q <= DLY_COUNT;
          end
        end
        DLY_COUNT: begin
          if (stepCyc_q != '0) begin
            stepCyc_q <= stepCyc_q - 1'b1;
          end else if (stepsLeft_q == 6'h01) begin
            stopClockRelease <= 1'b1;
            dlyState_q <= DLY_IDLE;
          end else begin
            stepsLeft_q <= stepsLeft_q - 1'b1;
            stepCyc_q <= STEP_CNT_W'(DELAY_STEP_CYC - 1);
          end
        end
        default: dlyState_q <= DLY_IDLE;
      endcase
    end
  end
endmodule

// ==== pmst_trap_config_asserts.sv ====
// checker: port timing of traps, forwarding, legacy ports and release pulse
`timescale 1ns/1ps
module pmst_trap_config_asserts
  import pmst_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ioValid,
  input wire logic ioWrite,
  input wire logic ioPosDecode,
  input wire logic ioTargetLpc,
  input wire logic ioClaim,
  input wire logic lpcForward,
  input wire logic commandPortSmiEnable,
  input wire logic legacyPortDecodeEnable,
  input wire logic systemMgmtInterrupt_b,
  input wire logic stopClockRelease,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioRdData,
  input wire logic [3:0] monitorTrapStatus,
  input wire logic [3:0] monitorTrapEnable,
  input wire logic [3:0] monitorTrapClear
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence cmd_write;
    ioValid && ioWrite && ioAddr == IO_CMD_PORT && legacyPortDecodeEnable;
  endsequence
  sequence plain_read;
    ioValid && !ioWrite && !ioClaim;
  endsequence
  chk_claim_fixed_ports: assert property (ioClaim == (ioValid && legacyPortDecodeEnable &&
    (ioAddr == IO_CMD_PORT || ioAddr == IO_SCRATCH_PORT))) else $error("claim mismatch");
  chk_forward_lpc_only: assert property (lpcForward |-> ioValid && ioTargetLpc)
    else $error("forward without lpc cycle");
  chk_trap_needs_enable: assert property ((monitorTrapStatus & ~$past(monitorTrapStatus) &
    ~$past(monitorTrapEnable)) == 4'h0) else $error("trap set while disabled");
  chk_trap_needs_decode: assert property (|(monitorTrapStatus & ~$past(monitorTrapStatus))
    |-> $past(ioValid && ioPosDecode)) else $error("trap set without decode");
  chk_trap_sticky: assert property (($past(monitorTrapStatus) & ~monitorTrapStatus &
    ~$past(monitorTrapClear)) == 4'h0) else $error("trap dropped without clear");
  chk_trap_raises_smi: assert property (|monitorTrapStatus |-> !systemMgmtInterrupt_b)
    else $error("trap pending but smi idle");
  chk_cmd_port_smi: assert property (cmd_write ##0 commandPortSmiEnable
    |=> !systemMgmtInterrupt_b) else $error("command write gave no smi");
  chk_unclaimed_read: assert property (plain_read |=> ioRdData == 8'h00)
    else $error("unclaimed read returned data");
  chk_release_single: assert property (stopClockRelease |=> !stopClockRelease [*8])
    else $error("release pulse too long");
endmodule
bind pmst_trap_config pmst_trap_config_asserts chk_u (.sys_clk, .rst_b, .ioValid, .ioWrite,
  .ioPosDecode, .ioTargetLpc, .ioClaim, .lpcForward, .commandPortSmiEnable,
  .legacyPortDecodeEnable, .systemMgmtInterrupt_b, .stopClockRelease, .ioAddr, .ioRdData,
  .monitorTrapStatus, .monitorTrapEnable, .monitorTrapClear);
